/* File: hdl/watchdog_reset_control.sv */
// Watchdog timer, reset sequencer and reset-initialised registers.
// Assumes a classic Wishbone master, synchronous pins, and a vector
// memory that answers vec_data_i in the same cycle as vec_rd_o.
// Contract
// - any write to the watchdog, or any reset, reloads it to 7FFF
// - unreloaded, MSB falls after 262144 clocks and forces a reset
// - watchdog reset reloads counter, releases, restarts from vector
// - watchdog disable level on reset pin suppresses watchdog resets
// - stop halts clock and watchdog; stop can be disabled at build
// - reset pin low over 2 us, then high, starts from vector
// - program counter loads high byte from FFFF, low from FFFE
// - reset sets interrupt disable flag until software clears it
// - reset clears port P0 to P4 direction registers
// - open drain port floats in reset, latch reads FF after
// - reset clears interrupt control and timer control registers
// - reset clears PWM register and five-bit DAC register
// - pin reset has top priority and is never masked
//
// The Wishbone interface to the registers is this design's own decision.
module watchdog_reset_control
  import watchdog_reset_pkg::*;
#(
  parameter bit STOP_ENABLE = 1'b1
)
(
  input wire logic clk_i, // Oscillator clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [ADR_W-1:0] adr_i, // Wishbone byte address
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  input wire logic we_i, // Wishbone write
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  output logic ack_o, // Wishbone acknowledge
  input wire logic reset_pin_n_i, // External reset pin
  input wire logic wdt_disable_i, // Elevated level on reset pin
  input wire logic stop_instruction_i, // Stop executed by the core
  input wire logic [7:0] vec_data_i, // Vector memory data
  output logic [15:0] vec_addr_o, // Vector memory address
  output logic vec_rd_o, // Vector memory read
  output logic [15:0] pc_o, // Program counter start value
  output logic pc_load_o, // Program counter load pulse
  output logic sys_reset_o, // System reset to the core
  output logic clk_run_o, // System clock enable
  output logic irq_disable_o, // Interrupt disable flag
  output logic [NDIR-1:0][7:0] port_dir_o, // P0 to P4 directions
  output logic [7:0] open_drain_port_o, // Open drain pin level
  output logic [7:0] open_drain_port_oe_o, // Open drain pin enable
  output logic [4:0] dac_o, // DAC register
  output logic [7:0] pwm_o, // PWM register
  output logic [7:0] prescaler_x_o, // Timer X prescaler
  output logic [7:0] timer_x_o, // Timer X
  output logic [7:0] int_ctrl_o, // Interrupt control register
  output logic [7:0] timer_ctrl_o // Timer control register
);

  // Map a register index onto its slot
  function automatic logic [3:0] slot_of(input logic [7:0] idx);
    logic [3:0] s;
    s = 4'(SLOT_NONE);
    for (int k = 0; k < NSLOT; k++)
    begin
      if (SLOT_IDX[k] == idx)
      begin
        s = 4'(k);
      end
    end
    return s;
  endfunction : slot_of

  seq_state_type state_reg;
  seq_state_type state_next;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] low_cnt_next;
  logic [CNT_W-1:0] hold_cnt_reg;
  logic [CNT_W-1:0] hold_cnt_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic pc_load_reg;
  logic pc_load_next;
  logic cause_reg;
  logic cause_next;
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic [WDT_W-1:0] wdt_reg;
  logic [WDT_W-1:0] wdt_next;
  logic [7:0] slot_reg [NSLOT];
  logic [7:0] slot_next [NSLOT];
  logic irq_dis_reg;
  logic irq_dis_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic in_reset;
  logic pin_rst;
  logic wdt_trip;
  logic tick;
  logic bus_req;
  logic bus_wr;
  logic [7:0] bus_idx;
  logic [3:0] bus_slot;

  // Decode of the sequencer and the bus
  assign in_reset = (state_reg == S_RESET);
  assign pin_rst = (low_cnt_reg == RST_LOW_LAST);
  assign wdt_trip = ~wdt_reg[WDT_MSB] & ~wdt_disable_i;
  assign tick = (div_reg == DIV_LAST);
  assign bus_req = cyc_i & stb_i & ~ack_reg;
  assign bus_wr = bus_req & we_i;
  assign bus_idx = adr_i[ADR_W-1:2];
  assign bus_slot = slot_of(bus_idx);

  // Reset sequencer: pin filter, hold, vector fetch, run and stop
  always_comb
  begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    pc_next = pc_reg;
    pc_load_next = 1'b0;
    cause_next = cause_reg;
    low_cnt_next = low_cnt_reg;
    if (reset_pin_n_i)
    begin
      low_cnt_next = '0;
    end
    else if (!pin_rst)
    begin
      low_cnt_next = low_cnt_reg + 1'b1;
    end
    unique case (state_reg)
      S_RESET:
      begin
        if (reset_pin_n_i)
        begin
          hold_cnt_next = hold_cnt_reg + 1'b1;
          if (hold_cnt_reg == RST_HOLD_LAST)
          begin
            state_next = S_VEC_LO;
          end
        end
        else
        begin
          hold_cnt_next = '0;
        end
      end
      S_VEC_LO:
      begin
        pc_next[7:0] = vec_data_i;
        state_next = S_VEC_HI;
      end
      S_VEC_HI:
      begin
        pc_next[15:8] = vec_data_i;
        pc_load_next = 1'b1;
        state_next = S_RUN;
      end
      S_RUN:
      begin
        if (wdt_trip)
        begin
          state_next = S_RESET;
          hold_cnt_next = '0;
          cause_next = 1'b1;
        end
        else if (STOP_ENABLE && stop_instruction_i)
        begin
          state_next = S_STOP;
        end
      end
      S_STOP:
      begin
        state_next = S_STOP;
      end
    endcase
    // Pin reset overrides every state and any mask
    if (pin_rst)
    begin
      state_next = S_RESET;
      hold_cnt_next = '0;
      cause_next = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= S_RESET;
      hold_cnt_reg <= '0;
      low_cnt_reg <= '0;
      pc_reg <= 16'h0000;
      pc_load_reg <= 1'b0;
      cause_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      low_cnt_reg <= low_cnt_next;
      pc_reg <= pc_next;
      pc_load_reg <= pc_load_next;
      cause_reg <= cause_next;
    end
  end

  // Divide by sixteen and the watchdog down-counter
  always_comb
  begin
    div_next = div_reg;
    wdt_next = wdt_reg;
    if (state_reg != S_STOP)
    begin
      div_next = div_reg + 1'b1;
    end
    if (in_reset || (bus_wr && bus_idx == IDX_WDT))
    begin
      wdt_next = WDT_RELOAD;
    end
    else if (tick && state_reg != S_STOP && wdt_reg != WDT_ZERO)
    begin
      wdt_next = wdt_reg - 1'b1;
    end
  end

  // Watchdog registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_reg <= 4'h0;
      wdt_reg <= WDT_RELOAD;
    end
    else
    begin
      div_reg <= div_next;
      wdt_reg <= wdt_next;
    end
  end

  // Register file writes, reset initialisation and bus answer
  always_comb
  begin
    for (int k = 0; k < NSLOT; k++)
    begin
      slot_next[k] = slot_reg[k];
      if (in_reset)
      begin
        slot_next[k] = SLOT_RST[k];
      end
      else if (bus_wr && sel_i[0] && bus_slot == 4'(k))
      begin
        slot_next[k] = dat_i[7:0] & SLOT_MASK[k];
      end
    end
    irq_dis_next = irq_dis_reg;
    if (in_reset)
    begin
      irq_dis_next = 1'b1;
    end
    else if (bus_wr && sel_i[0] && bus_idx == IDX_STAT)
    begin
      irq_dis_next = dat_i[STAT_IRQ_DIS];
    end
    ack_next = bus_req;
    rdata_next = 32'h0000_0000;
    if (bus_req && !we_i)
    begin
      if (bus_idx == IDX_WDT)
      begin
        rdata_next[WDT_W-1:0] = wdt_reg;
      end
      else if (bus_idx == IDX_STAT)
      begin
        rdata_next[STAT_IRQ_DIS] = irq_dis_reg;
        rdata_next[STAT_WDT_CAUSE] = cause_reg;
        rdata_next[STAT_STOPPED] = (state_reg == S_STOP);
      end
      else if (bus_slot != 4'(SLOT_NONE))
      begin
        rdata_next[7:0] = slot_reg[bus_slot];
      end
    end
  end

  // Register file flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int k = 0; k < NSLOT; k++)
      begin
        slot_reg[k] <= SLOT_RST[k];
      end
      irq_dis_reg <= 1'b1;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      for (int k = 0; k < NSLOT; k++)
      begin
        slot_reg[k] <= slot_next[k];
      end
      irq_dis_reg <= irq_dis_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Direction register outputs
  genvar g;
  generate
    for (g = 0; g < NDIR; g++)
    begin : g_dir
      assign port_dir_o[g] = slot_reg[g];
    end
  endgenerate

  // Open drain port floats while reset is held
  assign open_drain_port_o = 8'h00;
  assign open_drain_port_oe_o = in_reset ? 8'h00 : ~slot_reg[SLOT_P6];

  // Remaining outputs
  assign dac_o = slot_reg[SLOT_DAC][4:0];
  assign pwm_o = slot_reg[SLOT_PWM];
  assign prescaler_x_o = slot_reg[SLOT_PRX];
  assign timer_x_o = slot_reg[SLOT_TMX];
  assign int_ctrl_o = slot_reg[SLOT_ICR];
  assign timer_ctrl_o = slot_reg[SLOT_TCR];
  assign irq_disable_o = irq_dis_reg;
  assign sys_reset_o = in_reset;
  assign clk_run_o = (state_reg != S_STOP);
  assign vec_rd_o = (state_reg == S_VEC_LO) || (state_reg == S_VEC_HI);
  assign vec_addr_o = (state_reg == S_VEC_HI) ? VEC_HI_ADDR : VEC_LO_ADDR;
  assign pc_o = pc_reg;
  assign pc_load_o = pc_load_reg;
  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;

endmodule : watchdog_reset_control

/* File: hdl/watchdog_reset_pkg.sv */
// Constants for the watchdog and reset sequencer block.
// Assumes a 125 MHz clock that also serves as the oscillator count.
package watchdog_reset_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 125;
  localparam int RST_LOW_NS = 2000;
  localparam int RST_LOW_CYC = (RST_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] RST_LOW_LAST = CNT_W'(RST_LOW_CYC);
  localparam logic [CNT_W-1:0] RST_HOLD_LAST = 9'h007;
  localparam logic [3:0] DIV_LAST = 4'hF;
  localparam int WDT_TRIP_OSC = 262144;
  // Watchdog counter
  localparam int WDT_W = 15;
  localparam int WDT_MSB = 14;
  localparam logic [WDT_W-1:0] WDT_RELOAD = 15'h7FFF;
  localparam logic [WDT_W-1:0] WDT_ZERO = 15'h0000;
  // Bus layout: byte address is four times the register index
  localparam int ADR_W = 10;
  localparam logic [7:0] IDX_WDT = 8'hF4;
  localparam logic [7:0] IDX_STAT = 8'hC0;
  localparam int STAT_IRQ_DIS = 0;
  localparam int STAT_WDT_CAUSE = 1;
  localparam int STAT_STOPPED = 2;
  // Reset-initialised register slots
  localparam int NSLOT = 12;
  localparam int NDIR = 5;
  localparam int SLOT_P6 = 5;
  localparam int SLOT_DAC = 6;
  localparam int SLOT_PWM = 7;
  localparam int SLOT_PRX = 8;
  localparam int SLOT_TMX = 9;
  localparam int SLOT_ICR = 10;
  localparam int SLOT_TCR = 11;
  localparam int SLOT_NONE = 15;
  localparam logic [7:0] SLOT_IDX [NSLOT] = '{
    8'hE1, 8'hE3, 8'hE5, 8'hE9, 8'hEB, 8'hEE,
    8'hF0, 8'hF1, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
  localparam logic [7:0] SLOT_RST [NSLOT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] SLOT_MASK [NSLOT] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  // Reset vector
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;
  // Sequencer states
  typedef enum logic [2:0] {
    S_RESET,
    S_VEC_LO,
    S_VEC_HI,
    S_RUN,
    S_STOP
  } seq_state_type;
endpackage : watchdog_reset_pkg

/* File: test/reset_circuit_model.sv */
// External reset circuit that drives the reset pin.
// Assumes press is called from the bench's clocked sequence.
module reset_circuit_model
(
  input wire logic clk_i, // Clock
  output logic reset_pin_n_o, // Reset pin
  output logic wdt_disable_o // Elevated pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin rests high through its pull-up
  initial
  begin
    reset_pin_n_o = 1'b1;
    wdt_disable_o = 1'b0;
  end
  // Hold the pin low for n cycles, then let it rise
  task automatic press(input int n);
    @(posedge clk_i);
    reset_pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    reset_pin_n_o <= 1'b1;
  endtask : press
endmodule : reset_circuit_model

/* File: test/watchdog_reset_control_tb_top.sv */
// Self-checking bench for the watchdog and reset sequencer.
// Assumes the checker binds itself and a 125 MHz clock.
module watchdog_reset_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic we_i = 1'b0;
  logic [3:0] sel_i = '0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic stop_instruction_i = 1'b0;
  logic [7:0] vec_data_i;
  logic [31:0] dat_o;
  logic ack_o, reset_pin_n_i, wdt_disable_i, vec_rd_o, pc_load_o, sys_reset_o, clk_run_o;
  logic irq_disable_o;
  logic [15:0] vec_addr_o, pc_o;
  logic [4:0][7:0] port_dir_o;
  logic [7:0] od_o, od_oe_o, pwm_o, presc_o, tmx_o, ictl_o, tctl_o;
  logic [4:0] dac_o;
  int num_errors = 0;
  int compares = 0;
  // Vector memory answers in the same cycle
  assign vec_data_i = (vec_addr_o == 16'hFFFF) ? 8'hA5 :
    (vec_addr_o == 16'hFFFE) ? 8'h3C : ~vec_addr_o[7:0];
  always #4 clk_i = ~clk_i;
  watchdog_reset_control u_watchdog_reset_control (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .reset_pin_n_i(reset_pin_n_i), .wdt_disable_i(wdt_disable_i),
    .stop_instruction_i(stop_instruction_i), .vec_data_i(vec_data_i),
    .vec_addr_o(vec_addr_o), .vec_rd_o(vec_rd_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
    .sys_reset_o(sys_reset_o), .clk_run_o(clk_run_o), .irq_disable_o(irq_disable_o),
    .port_dir_o(port_dir_o), .open_drain_port_o(od_o), .open_drain_port_oe_o(od_oe_o),
    .dac_o(dac_o), .pwm_o(pwm_o), .prescaler_x_o(presc_o), .timer_x_o(tmx_o),
    .int_ctrl_o(ictl_o), .timer_ctrl_o(tctl_o));
  reset_circuit_model u_reset_circuit_model (
    .clk_i(clk_i), .reset_pin_n_o(reset_pin_n_i), .wdt_disable_o(wdt_disable_i));
  // Verdict and end of run
  task automatic results();
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One classic bus cycle, released after the acknowledging edge
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    n = 0;
    // Ack and read data are taken at the rising edge that samples ack high
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 64);
    if (ack_o !== 1'b1)
    begin
      num_errors++;
      results();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask : rd
  // Wait for the start pulse and check the start state
  task automatic boot_check();
    int n;
    n = 0;
    while (pc_load_o !== 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    // A start pulse that never comes ends the run as a failure
    if (pc_load_o !== 1'b1)
    begin
      num_errors++;
      results();
    end
    chk(pc_o, 16'hA53C);
    chk(irq_disable_o, 1'b1);
    chk(port_dir_o === '0, 1'b1);
    chk(od_oe_o, 8'h00);
    chk(od_o, 8'h00);
    chk({ictl_o, tctl_o}, 16'h0000);
    chk({pwm_o, 3'h0, dac_o}, 16'h0000);
    chk({presc_o, tmx_o}, 16'hFF01);
  endtask : boot_check
  // Move registers off their reset values
  task automatic t_registers();
    logic [31:0] q;
    wr(10'h3C0, 32'hFF);
    wr(10'h3C4, 32'hA5);
    wr(10'h3F0, 32'h12);
    wr(10'h3F4, 32'h34);
    wr(10'h3F8, 32'h56);
    wr(10'h3FC, 32'h78);
    wr(10'h384, 32'hF0);
    wr(10'h3B8, 32'h0F);
    wr(10'h300, 32'h0);
    rd(10'h3C0, q);
    chk(q, 32'h1F);
    rd(10'h200, q);
    chk(q, 32'h0);
    // Look at the register outputs away from the clock edge
    @(negedge clk_i);
    chk(irq_disable_o, 1'b0);
    chk({pwm_o, presc_o, tmx_o, tctl_o}, 32'hA5123478);
    chk({ictl_o, port_dir_o[0], od_oe_o}, 24'h56F0F0);
  endtask : t_registers
  // Reload by any data, then count at one sixteenth of the clock
  task automatic t_watchdog();
    logic [31:0] q;
    wr(10'h3D0, 32'h1234);
    rd(10'h3D0, q);
    chk(q >= 32'h7FFE && q <= 32'h7FFF, 1'b1);
    repeat (160) @(posedge clk_i);
    rd(10'h3D0, q);
    chk(q >= 32'h7FF3 && q <= 32'h7FF5, 1'b1);
  endtask : t_watchdog
  // A short low is ignored, a long one restarts from the vector
  task automatic t_pin();
    u_reset_circuit_model.press(100);
    @(negedge clk_i);
    chk(sys_reset_o, 1'b0);
    fork
      u_reset_circuit_model.press(260);
      begin
        repeat (258) @(negedge clk_i);
        chk(sys_reset_o, 1'b1);
        chk(od_oe_o, 8'h00);
      end
    join
    boot_check();
  endtask : t_pin
  // Stop freezes the clock and the watchdog until a pin reset
  task automatic t_stop();
    logic [31:0] p, q;
    @(posedge clk_i);
    stop_instruction_i <= 1'b1;
    @(posedge clk_i);
    stop_instruction_i <= 1'b0;
    @(negedge clk_i);
    chk(clk_run_o, 1'b0);
    rd(10'h3D0, p);
    repeat (64) @(posedge clk_i);
    rd(10'h3D0, q);
    chk(q, p);
    u_reset_circuit_model.press(260);
    boot_check();
    chk(clk_run_o, 1'b1);
    // The pin reset reloads the frozen count
    rd(10'h3D0, q);
    chk(q >= 32'h7FFE && q <= 32'h7FFF, 1'b1);
  endtask : t_stop
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    boot_check();
    t_registers();
    t_watchdog();
    t_pin();
    t_registers();
    t_stop();
    results();
  end
endmodule : watchdog_reset_control_tb_top

/* File: test/watchdog_reset_properties.sv */
// Port checker for the watchdog and reset sequencer.
// Assumes one clock domain and the synchronous rst_i of the design.
module watchdog_reset_checker
  import watchdog_reset_pkg::*;
#(
  parameter bit STOP_ENABLE = 1'b1
)
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic ack_o, // Bus ack
  input wire logic reset_pin_n_i, // Reset pin
  input wire logic stop_instruction_i, // Stop
  input wire logic [7:0] vec_data_i, // Vector data
  input wire logic [15:0] vec_addr_o, // Vector address
  input wire logic vec_rd_o, // Vector read
  input wire logic [15:0] pc_o, // Start value
  input wire logic pc_load_o, // Start pulse
  input wire logic sys_reset_o, // Core reset
  input wire logic clk_run_o, // Clock enable
  input wire logic irq_disable_o, // Interrupt disable
  input wire logic [NDIR-1:0][7:0] port_dir_o, // Directions
  input wire logic [7:0] open_drain_port_oe_o, // Drain enable
  input wire logic [4:0] dac_o, // DAC
  input wire logic [7:0] pwm_o, // PWM
  input wire logic [7:0] prescaler_x_o, // Prescaler
  input wire logic [7:0] timer_x_o, // Timer X
  input wire logic [7:0] int_ctrl_o, // Interrupt control
  input wire logic [7:0] timer_ctrl_o // Timer control
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Two steps of the vector fetch
  sequence vec_lo_s;
    vec_rd_o && vec_addr_o == 16'hFFFE;
  endsequence
  sequence vec_hi_s;
    vec_rd_o && vec_addr_o == 16'hFFFF;
  endsequence
  a_ack_single:
    assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_vec_order:
    assert property (vec_lo_s |=> vec_hi_s ##1 pc_load_o) else $error("vector order");
  a_pc_bytes:
    assert property (pc_load_o |-> pc_o == {$past(vec_data_i), $past(vec_data_i, 2)})
    else $error("start value");
  a_flag_set:
    assert property (pc_load_o |-> irq_disable_o) else $error("flag clear");
  a_init_regs:
    assert property (pc_load_o |-> port_dir_o == '0 && dac_o == 5'h00 && pwm_o == 8'h00
      && prescaler_x_o == 8'hFF && timer_x_o == 8'h01 && int_ctrl_o == 8'h00
      && timer_ctrl_o == 8'h00) else $error("init values");
  a_drain_off:
    assert property (sys_reset_o |-> open_drain_port_oe_o == 8'h00) else $error("drain on");
  a_pin_holds:
    assert property (!reset_pin_n_i && sys_reset_o |=> sys_reset_o) else $error("left reset");
  a_stop_halts:
    assert property (STOP_ENABLE && stop_instruction_i && clk_run_o && !sys_reset_o
      && !vec_rd_o |=> !clk_run_o) else $error("stop ignored");
endmodule : watchdog_reset_checker

bind watchdog_reset_control watchdog_reset_checker #(.STOP_ENABLE(STOP_ENABLE)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ack_o(ack_o), .reset_pin_n_i(reset_pin_n_i),
  .stop_instruction_i(stop_instruction_i), .vec_data_i(vec_data_i),
  .vec_addr_o(vec_addr_o), .vec_rd_o(vec_rd_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
  .sys_reset_o(sys_reset_o), .clk_run_o(clk_run_o), .irq_disable_o(irq_disable_o),
  .port_dir_o(port_dir_o), .open_drain_port_oe_o(open_drain_port_oe_o), .dac_o(dac_o),
  .pwm_o(pwm_o), .prescaler_x_o(prescaler_x_o), .timer_x_o(timer_x_o),
  .int_ctrl_o(int_ctrl_o), .timer_ctrl_o(timer_ctrl_o));
